// File: verilog/frx_rx_status.sv
// Purpose: Receive alarm-code register bank with code store and status
// Assumes: Code detector runs on core_clk_in; codes arrive as 1-cycle pulses
// Notes: Read data is valid only in the cycle after the read strobe
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module frx_rx_status #(
  parameter int FIFO_DEPTH = frx_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [frx_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [frx_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [frx_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic code_valid_in,
  input wire logic [frx_pkg::CODE_W-1:0] code_bits_in,
  input wire logic codeword_active_in,
  input wire logic idle_active_in,
  input wire logic port_global_irq_enable_in,
  output logic detector_reset_out,
  output logic irq_out
);
  localparam int FW = frx_pkg::FLAG_W;
  localparam int DW = frx_pkg::DATA_W;
  localparam int CNT_W = $clog2(FIFO_DEPTH+1);

  logic rx_code_soft_reset;
  logic [FW-1:0] irq_en_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rd_word;
  logic rx_codeword_present;
  logic rx_idle_present;
  logic cw_prev_reg;
  logic idle_prev_reg;
  logic [FW-1:0] flag_set;
  logic [FW-1:0] flag_clr;
  logic [FW-1:0] latched;
  logic rx_code_fifo_empty;
  logic fifo_full;
  logic fifo_overflow;
  logic [frx_pkg::CODE_W-1:0] fifo_head;
  logic [CNT_W-1:0] fifo_count;
  logic code_push;
  logic code_pop;
  logic wr_control;
  logic wr_latched;
  logic wr_irq_en;
  logic rd_fifo;

  function automatic logic reg_hit(
    input logic [frx_pkg::ADDR_W-1:0] addr,
    input logic [frx_pkg::ADDR_W-1:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // Register strobes
  assign wr_control = reg_wr_in && reg_hit(reg_addr_in, frx_pkg::OFS_CONTROL);
  assign wr_latched = reg_wr_in && reg_hit(reg_addr_in, frx_pkg::OFS_LATCHED);
  assign wr_irq_en = reg_wr_in && reg_hit(reg_addr_in, frx_pkg::OFS_IRQ_EN);
  assign rd_fifo = reg_rd_in && reg_hit(reg_addr_in, frx_pkg::OFS_FIFO_DATA);

  // Control register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_code_soft_reset <= frx_pkg::CONTROL_RST;
    end else if (wr_control) begin
      rx_code_soft_reset <= reg_wdata_in[frx_pkg::BIT_SOFT_RST];
    end
  end

  assign detector_reset_out = rx_code_soft_reset;

  // Interrupt enable register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_en_reg <= frx_pkg::IRQ_EN_RST;
    end else if (wr_irq_en) begin
      irq_en_reg <= reg_wdata_in[FW-1:0];
    end
  end

  // Live status, forced low while the receiver is held in reset
  assign rx_codeword_present = codeword_active_in && !rx_code_soft_reset;
  assign rx_idle_present = idle_active_in && !rx_code_soft_reset;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cw_prev_reg <= 1'h0;
      idle_prev_reg <= 1'h0;
    end else begin
      cw_prev_reg <= rx_codeword_present;
      idle_prev_reg <= rx_idle_present;
    end
  end

  // Code store
  assign code_push = code_valid_in && !rx_code_soft_reset;
  assign code_pop = rd_fifo;

  frx_code_fifo #(
    .WIDTH(frx_pkg::CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .flush_in(rx_code_soft_reset),
    .push_in(code_push),
    .data_in(code_bits_in),
    .pop_in(code_pop),
    .head_out(fifo_head),
    .empty_out(rx_code_fifo_empty),
    .full_out(fifo_full),
    .overflow_out(fifo_overflow),
    .count_out(fifo_count)
  );

  // Latched flag events
  always_comb begin
    flag_set = frx_pkg::FLAGS_NONE;
    flag_set[frx_pkg::BIT_IDLE] = rx_idle_present && !idle_prev_reg;
    flag_set[frx_pkg::BIT_CODEWORD] = rx_codeword_present && !cw_prev_reg;
    flag_set[frx_pkg::BIT_OVERFLOW] = fifo_overflow;
  end

  assign flag_clr = wr_latched ? reg_wdata_in[FW-1:0] : frx_pkg::FLAGS_NONE;

  for (genvar i = 0; i < FW; i++) begin : g_flag
    frx_sticky_flag #(
      .RST_VAL(frx_pkg::LATCHED_RST[i])
    ) u_flag (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .set_in(flag_set[i]),
      .clr_in(flag_clr[i]),
      .flag_out(latched[i])
    );
  end

  assign irq_out = port_global_irq_enable_in && |(latched & irq_en_reg);

  // Read multiplexer
  always_comb begin
    rd_word = frx_pkg::ZERO_WORD;
    if (reg_hit(reg_addr_in, frx_pkg::OFS_CONTROL)) begin
      rd_word[frx_pkg::BIT_SOFT_RST] = rx_code_soft_reset;
    end else if (reg_hit(reg_addr_in, frx_pkg::OFS_STATUS)) begin
      rd_word[frx_pkg::BIT_EMPTY] = rx_code_fifo_empty;
      rd_word[frx_pkg::BIT_CODEWORD] = rx_codeword_present;
      rd_word[frx_pkg::BIT_IDLE] = rx_idle_present;
    end else if (reg_hit(reg_addr_in, frx_pkg::OFS_LATCHED)) begin
      rd_word[FW-1:0] = latched;
    end else if (reg_hit(reg_addr_in, frx_pkg::OFS_IRQ_EN)) begin
      rd_word[FW-1:0] = irq_en_reg;
    end else if (reg_hit(reg_addr_in, frx_pkg::OFS_FIFO_DATA)) begin
      rd_word[frx_pkg::BIT_INVALID] = rx_code_fifo_empty;
      if (!rx_code_fifo_empty) begin
        rd_word[frx_pkg::CODE_W-1:0] = fifo_head;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= frx_pkg::ZERO_WORD;
    end else if (reg_rd_in) begin
      rdata_reg <= rd_word;
    end else begin
      rdata_reg <= frx_pkg::ZERO_WORD;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_cw_rise;
    !rx_codeword_present ##1 rx_codeword_present;
  endsequence

  sequence s_idle_rise;
    !rx_idle_present ##1 rx_idle_present;
  endsequence

  sequence s_status_read;
    reg_rd_in && reg_hit(reg_addr_in, frx_pkg::OFS_STATUS);
  endsequence

  sequence s_data_read;
    rd_fifo;
  endsequence

  a_soft_rst_flush: assert property (
    rx_code_soft_reset |=> rx_code_fifo_empty && !rx_codeword_present && !rx_idle_present
  ) else $error("store not flushed or status live during soft reset");

  a_resume_push: assert property (
    !rx_code_soft_reset && code_valid_in && rx_code_fifo_empty |=> !rx_code_fifo_empty
  ) else $error("code not stored after soft reset release");

  a_empty_status: assert property (
    s_status_read |=> reg_rdata_out[frx_pkg::BIT_EMPTY] == $past(fifo_count == '0)
  ) else $error("empty status bit does not match store level");

  a_cw_status: assert property (
    s_status_read |=>
      reg_rdata_out[frx_pkg::BIT_CODEWORD] ==
      $past(codeword_active_in && !rx_code_soft_reset)
  ) else $error("codeword status bit wrong");

  a_idle_status: assert property (
    s_status_read |=>
      reg_rdata_out[frx_pkg::BIT_IDLE] == $past(idle_active_in && !rx_code_soft_reset)
  ) else $error("idle status bit wrong");

  a_overflow_set: assert property (
    code_valid_in && !rx_code_soft_reset && fifo_full && !rd_fifo
      |=> latched[frx_pkg::BIT_OVERFLOW] && fifo_full
  ) else $error("overflow not latched or store level changed");

  a_cw_latch: assert property (
    s_cw_rise |=> latched[frx_pkg::BIT_CODEWORD]
  ) else $error("codeword rise not latched");

  a_idle_latch: assert property (
    s_idle_rise |=> latched[frx_pkg::BIT_IDLE]
  ) else $error("idle rise not latched");

  a_idle_after_rst: assert property (
    $fell(sys_rst_in) |-> latched[frx_pkg::BIT_IDLE]
  ) else $error("latched idle not set after reset");

  a_irq_gate: assert property (
    irq_out == (port_global_irq_enable_in &&
      ((latched[0] && irq_en_reg[0]) || (latched[1] && irq_en_reg[1]) ||
       (latched[2] && irq_en_reg[2])))
  ) else $error("interrupt output not gated by enables");

  a_invalid_bit: assert property (
    rd_fifo |=> reg_rdata_out[frx_pkg::BIT_INVALID] == $past(fifo_count == '0)
  ) else $error("invalid bit does not match store level");

  a_code_order: assert property (
    code_valid_in && !rx_code_soft_reset && fifo_count == '0 && !rd_fifo
      ##1 rd_fifo && !code_valid_in
      |=> reg_rdata_out[frx_pkg::CODE_W-1:0] == $past(code_bits_in, 2)
  ) else $error("code bits not presented in arrival order");

  a_pop_advance: assert property (
    rd_fifo && !rx_code_fifo_empty && !code_valid_in && !rx_code_soft_reset
      |=> fifo_count == CNT_W'($past(fifo_count) - 1'b1)
  ) else $error("store did not advance on data read");

  a_unmapped_zero: assert property (
    reg_rd_in && !reg_hit(reg_addr_in, frx_pkg::OFS_CONTROL) &&
      !reg_hit(reg_addr_in, frx_pkg::OFS_STATUS) &&
      !reg_hit(reg_addr_in, frx_pkg::OFS_LATCHED) &&
      !reg_hit(reg_addr_in, frx_pkg::OFS_IRQ_EN) &&
      !reg_hit(reg_addr_in, frx_pkg::OFS_FIFO_DATA)
      |=> reg_rdata_out == frx_pkg::ZERO_WORD
  ) else $error("unmapped address read nonzero");

  a_w1c_clear: assert property (
    wr_latched && reg_wdata_in[frx_pkg::BIT_CODEWORD] &&
      !(rx_codeword_present && !cw_prev_reg)
      |=> !latched[frx_pkg::BIT_CODEWORD]
  ) else $error("latched codeword flag not cleared by write of one");

  a_set_beats_clr: assert property (
    wr_latched && reg_wdata_in[frx_pkg::BIT_IDLE] && rx_idle_present && !idle_prev_reg
      |=> latched[frx_pkg::BIT_IDLE]
  ) else $error("idle event lost to a same-cycle clear");

  a_rdata_one_cycle: assert property (
    !reg_rd_in |=> reg_rdata_out == frx_pkg::ZERO_WORD
  ) else $error("read data held beyond its cycle");

  a_ctrl_write: assert property (
    wr_control
      |=> rx_code_soft_reset == $past(reg_wdata_in[frx_pkg::BIT_SOFT_RST])
  ) else $error("soft-reset bit not written");

  a_det_rst_copy: assert property (
    detector_reset_out == rx_code_soft_reset
  ) else $error("detector reset does not follow soft-reset bit");

  a_ctrl_read: assert property (
    reg_rd_in && reg_hit(reg_addr_in, frx_pkg::OFS_CONTROL)
      |=> reg_rdata_out == {{(DW-1){1'b0}}, $past(rx_code_soft_reset)}
  ) else $error("control register read wrong");

  a_latched_read: assert property (
    reg_rd_in && reg_hit(reg_addr_in, frx_pkg::OFS_LATCHED)
      |=> reg_rdata_out == {{(DW-FW){1'b0}}, $past(latched)}
  ) else $error("latched register read wrong");

  a_irq_en_write: assert property (
    wr_irq_en |=> irq_en_reg == $past(reg_wdata_in[FW-1:0])
  ) else $error("interrupt enable not written");

  a_irq_en_read: assert property (
    reg_rd_in && reg_hit(reg_addr_in, frx_pkg::OFS_IRQ_EN)
      |=> reg_rdata_out == {{(DW-FW){1'b0}}, $past(irq_en_reg)}
  ) else $error("interrupt enable read wrong");

  a_overflow_lost: assert property (
    fifo_overflow |=> fifo_count == $past(fifo_count)
  ) else $error("overflowing code changed the store level");

  a_empty_read_hold: assert property (
    rd_fifo && rx_code_fifo_empty && !code_push
      |=> rx_code_fifo_empty
  ) else $error("read of empty store changed its level");

  a_store_bound: assert property (
    fifo_count <= CNT_W'(FIFO_DEPTH)
  ) else $error("store level beyond its depth");

  a_data_read_zero: assert property (
    s_data_read ##1 !reg_rd_in |=> reg_rdata_out == frx_pkg::ZERO_WORD
  ) else $error("data read result held a second cycle");

endmodule : frx_rx_status

// File: pkg/frx_pkg.sv
// Purpose: Shared constants for the receive alarm-code status block
// Assumes: Byte addresses on an 8-bit register address port, 16-bit data
// Notes: Field positions are bit indices within a 16-bit register word
package frx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CODE_W = 6;
  localparam int FLAG_W = 3;
  localparam int FIFO_DEPTH = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'hD0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'hD4;
  localparam logic [ADDR_W-1:0] OFS_LATCHED = 8'hD6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'hD8;
  localparam logic [ADDR_W-1:0] OFS_FIFO_DATA = 8'hDC;

  // Control register field
  localparam int BIT_SOFT_RST = 0;

  // Status, latched status and enable fields
  localparam int BIT_IDLE = 0;
  localparam int BIT_CODEWORD = 1;
  localparam int BIT_OVERFLOW = 2;
  localparam int BIT_EMPTY = 3;

  // FIFO data register fields
  localparam int BIT_INVALID = 7;

  // Reset values
  localparam logic CONTROL_RST = 1'h0;
  localparam logic [FLAG_W-1:0] LATCHED_RST = 3'h1;
  localparam logic [FLAG_W-1:0] IRQ_EN_RST = 3'h0;
  localparam logic [FLAG_W-1:0] FLAGS_NONE = 3'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
endpackage : frx_pkg

// File: verilog/frx_sticky_flag.sv
// Purpose: One sticky status flag, set by hardware, cleared by software
// Assumes: Synchronous active-high reset
// Notes: A set in the clearing cycle wins
`timescale 1ns/10ps
module frx_sticky_flag #(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  logic flag_reg;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      flag_reg <= RST_VAL;
    end else if (set_in) begin
      flag_reg <= 1'h1;
    end else if (clr_in) begin
      flag_reg <= 1'h0;
    end
  end

  assign flag_out = flag_reg;
endmodule : frx_sticky_flag

// File: verilog/frx_code_fifo.sv
// Purpose: Circular store for received six-bit codes
// Assumes: Push and pop come from logic on the same clock
// Notes: A push into a full store is dropped and flagged unless a pop comes in the same cycle
`timescale 1ns/10ps
module frx_code_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic flush_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic empty_out,
  output logic full_out,
  output logic overflow_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_push;
  logic do_pop;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_step

  assign empty_out = (count_reg == '0);
  assign full_out = (count_reg == FULL_CNT);
  assign do_pop = pop_in && !empty_out;
  assign do_push = push_in && (!full_out || do_pop);
  assign overflow_out = push_in && full_out && !do_pop;
  assign head_out = mem[rd_ptr_reg];
  assign count_out = count_reg;

  always_ff @(posedge core_clk_in) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (do_pop) begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      if (do_push && !do_pop) begin
        count_reg <= CW'(count_reg + 1'b1);
      end else if (do_pop && !do_push) begin
        count_reg <= CW'(count_reg - 1'b1);
      end
    end
  end
endmodule : frx_code_fifo

// File: dv/frx_far_model.sv
// Purpose: Far-end source of alarm codes and live detector levels
// Assumes: Detector outputs change just after a rising core clock edge
// Notes: Code lines carry the inverse of the last code between strobes
`timescale 1ns/10ps
module frx_far_model (
  input wire logic core_clk_in,
  output logic code_valid_out,
  output logic [frx_pkg::CODE_W-1:0] code_bits_out,
  output logic codeword_active_out,
  output logic idle_active_out
);
  initial begin
    code_valid_out = 1'h0;
    code_bits_out = 6'h2A;
    codeword_active_out = 1'h0;
    idle_active_out = 1'h0;
  end

  // One code per strobe, first received bit in bit 0
  task automatic send(input logic [frx_pkg::CODE_W-1:0] code);
    @(posedge core_clk_in);
    code_valid_out <= 1'h1;
    code_bits_out <= code;
    @(posedge core_clk_in);
    code_valid_out <= 1'h0;
    code_bits_out <= ~code;
  endtask : send

  task automatic set_live(input logic cw, input logic idle);
    @(posedge core_clk_in);
    codeword_active_out <= cw;
    idle_active_out <= idle;
  endtask : set_live
endmodule : frx_far_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the receive alarm-code register bank
// Assumes: Code store depth set to 4 so overflow is reached quickly
// Notes: Read data is sampled in the single cycle after the read strobe
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'h0;
  logic rst;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr_s;
  logic rd_s;
  logic glob;
  logic [15:0] rdata;
  logic cv;
  logic [5:0] cb;
  logic cw;
  logic idle;
  logic det_rst;
  logic irq;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  frx_far_model far_u (.core_clk_in(clk), .code_valid_out(cv), .code_bits_out(cb),
    .codeword_active_out(cw), .idle_active_out(idle));

  frx_rx_status #(.FIFO_DEPTH(4)) dut_u (.core_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .code_valid_in(cv), .code_bits_in(cb),
    .codeword_active_in(cw), .idle_active_in(idle),
    .port_global_irq_enable_in(glob), .detector_reset_out(det_rst), .irq_out(irq));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
    #1;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1;
    chk(rdata, exp, $sformatf("read %h", a));
  endtask : rchk

  task automatic t_reset();
    rchk(8'hD6, 16'h0001);
    rchk(8'hD8, 16'h0000);
    rchk(8'hD0, 16'h0000);
    rchk(8'hD4, 16'h0008);
    rchk(8'hDC, 16'h0080);
    chk({15'h0000, irq}, 16'h0000, "irq after reset");
  endtask : t_reset

  task automatic t_map();
    logic [7:0] holes [3];
    holes = '{8'hD2, 8'hDA, 8'hDE};
    wr(8'hD4, 16'hFFFF);
    wr(8'hDC, 16'hFFFF);
    wr(8'hD0, 16'hFFFE);
    wr(8'hD8, 16'hFFF8);
    foreach (holes[i]) begin
      wr(holes[i], 16'hFFFF);
      rchk(holes[i], 16'h0000);
    end
    rchk(8'hD4, 16'h0008);
    rchk(8'hD0, 16'h0000);
    rchk(8'hD8, 16'h0000);
  endtask : t_map

  task automatic t_fifo();
    fork
      far_u.send(6'h0C);
      begin
        @(posedge clk);
        rchk(8'hDC, 16'h000C);
      end
    join
    far_u.send(6'h01);
    far_u.send(6'h20);
    rchk(8'hD4, 16'h0000);
    rchk(8'hDC, 16'h0001);
    rchk(8'hDC, 16'h0020);
    rchk(8'hDC, 16'h0080);
    rchk(8'hD4, 16'h0008);
  endtask : t_fifo

  task automatic t_overflow();
    wr(8'hD6, 16'h0007);
    for (int i = 1; i <= 5; i++) begin
      far_u.send(6'(i));
    end
    rchk(8'hD6, 16'h0004);
    wr(8'hD6, 16'h0000);
    rchk(8'hD6, 16'h0004);
    wr(8'hD6, 16'h0004);
    rchk(8'hD6, 16'h0000);
    for (int i = 1; i <= 4; i++) begin
      rchk(8'hDC, 16'(i));
    end
    rchk(8'hDC, 16'h0080);
  endtask : t_overflow

  task automatic t_live();
    far_u.set_live(1'h1, 1'h0);
    rchk(8'hD4, 16'h000A);
    rchk(8'hD6, 16'h0002);
    wr(8'hD6, 16'h0002);
    rchk(8'hD6, 16'h0000);
    fork
      far_u.set_live(1'h0, 1'h1);
      wr(8'hD6, 16'h0001);
    join
    rchk(8'hD4, 16'h0009);
    rchk(8'hD6, 16'h0001);
    far_u.set_live(1'h0, 1'h0);
    rchk(8'hD4, 16'h0008);
  endtask : t_live

  task automatic t_irq();
    @(posedge clk);
    glob <= 1'h1;
    wr(8'hD8, 16'h0001);
    chk({15'h0000, irq}, 16'h0001, "idle irq");
    @(posedge clk);
    glob <= 1'h0;
    #1;
    chk({15'h0000, irq}, 16'h0000, "global off");
    @(posedge clk);
    glob <= 1'h1;
    wr(8'hD6, 16'h0001);
    chk({15'h0000, irq}, 16'h0000, "idle cleared");
    wr(8'hD8, 16'h0002);
    far_u.set_live(1'h1, 1'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0001, "codeword irq");
    wr(8'hD8, 16'h0004);
    chk({15'h0000, irq}, 16'h0000, "codeword masked");
    wr(8'hD6, 16'h0002);
    far_u.set_live(1'h0, 1'h0);
    for (int i = 1; i <= 5; i++) begin
      far_u.send(6'h3F);
    end
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0001, "overflow irq");
  endtask : t_irq

  task automatic t_soft();
    wr(8'hD0, 16'h0001);
    chk({15'h0000, det_rst}, 16'h0001, "detector held");
    rchk(8'hD4, 16'h0008);
    far_u.set_live(1'h1, 1'h1);
    far_u.send(6'h15);
    rchk(8'hD4, 16'h0008);
    rchk(8'hDC, 16'h0080);
    far_u.set_live(1'h0, 1'h0);
    wr(8'hD0, 16'h0000);
    chk({15'h0000, det_rst}, 16'h0000, "detector free");
    far_u.send(6'h15);
    rchk(8'hDC, 16'h0015);
  endtask : t_soft

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: run exceeded its cycle budget", $time);
      summarize();
    end
  end

  initial begin
    rst <= 1'h1;
    addr <= 8'h00;
    wdata <= 16'h0000;
    wr_s <= 1'h0;
    rd_s <= 1'h0;
    glob <= 1'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_map();
    t_fifo();
    t_overflow();
    t_live();
    t_irq();
    t_soft();
    summarize();
  end
endmodule : tb_top
